// [hw/ebmt_defines.vh]
/*
 Constants for the eight-bit modulo interval timer: register
 indices, control field positions, reset values and divider ratios.
 Assumes it is included by bare name from the timer's design files.
*/
`ifndef EBMT_DEFINES_VH
`define EBMT_DEFINES_VH

// Register indices; byte address is four times the index
`define EBMT_IDX_CTRL 8'h00
`define EBMT_IDX_STAT 8'h01
`define EBMT_IDX_COUNT 8'h02
`define EBMT_IDX_MODULO 8'h03
`define EBMT_IDX_MASK 8'h04

// Control register field positions
`define EBMT_B_RUN 0
`define EBMT_B_CLEAR 1
`define EBMT_B_SEL_LO 2
`define EBMT_B_SEL_HI 3
`define EBMT_B_ALLOW 4
`define EBMT_B_GIE 5
`define EBMT_B_REQ 6

// Reset values
`define EBMT_RST_MODULO 8'hff
`define EBMT_RST_RUN 1'b1
`define EBMT_RST_SEL 2'b00

// Count pulse select codes (high bit, low bit)
`define EBMT_SEL_DIV256 2'b00
`define EBMT_SEL_DIV32 2'b01
`define EBMT_SEL_DIV2048 2'b10
`define EBMT_SEL_EXT 2'b11

// Divider ratios of the system clock
`define EBMT_DIV_SLOW 2048
`define EBMT_DIV_MID 256
`define EBMT_DIV_FAST 32

// AXI responses
`define EBMT_RESP_OKAY 2'b00
`define EBMT_RESP_SLVERR 2'b10

`endif

// [hw/ebmt_pulse_gen.v]
/*
 Count pulse generator: free-running system clock prescaler and
 event pin synchroniser, with the four-way pulse source select.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "ebmt_defines.vh"

module ebmt_pulse_gen #(
   parameter DIV_SLOW = `EBMT_DIV_SLOW,
   parameter DIV_MID = `EBMT_DIV_MID,
   parameter DIV_FAST = `EBMT_DIV_FAST
) (
   input wire aclk,
   input wire aresetn,
   input wire [1:0] sel,
   input wire event_in,
   output wire pulse
);
   localparam PW = $clog2(DIV_SLOW);

   reg [PW-1:0] scale_q;
   reg sync1_q;
   reg sync2_q;
   reg sync3_q;
   reg pulse_r;

   // True on the last state of each divide-by-n window
   function tap;
      input [PW-1:0] v;
      input integer n;
      begin
         tap = (v % n) == n - 1;
      end
   endfunction

   // Prescaler never resets except at system reset
   always @(posedge aclk) begin
      if (!aresetn) begin
         scale_q <= {PW{1'b0}};
      end else begin
         scale_q <= scale_q + {{(PW-1){1'b0}}, 1'b1};
      end
   end

   // Two-stage synchroniser plus a history stage for edge detection
   always @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
      end else begin
         sync1_q <= event_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // Source select; each rising event edge yields one pulse
   always @* begin
      case (sel)
         `EBMT_SEL_DIV256: pulse_r = tap(scale_q, DIV_MID);
         `EBMT_SEL_DIV32: pulse_r = tap(scale_q, DIV_FAST);
         `EBMT_SEL_DIV2048: pulse_r = tap(scale_q, DIV_SLOW);
         `EBMT_SEL_EXT: pulse_r = sync2_q & ~sync3_q;
         default: pulse_r = 1'b0;
      endcase
   end

   assign pulse = pulse_r;

endmodule

// [hw/ebmt_top.v]
/*
 Eight-bit modulo interval timer with an AXI4-Lite register slave,
 interrupt status/mask and a service request to the processor core.
 Assumes one clock, synchronous active-low reset, and a core that
 pulses service_ack when it accepts the timer request.
*/
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
// Summary of operation
// - Eight-bit up counter from zero, per pulse
// - Count clears on reset, match, clear write
// - Modulo resets to FFH, loaded by transfer
// - Modulo write-only, count read-only
// - Match on pulse after count equals modulo
// - Match zeroes count, sets request flag
// - Service needs global enable and allow flag
// - Acceptance clears request flag
// - Two select bits choose four pulse sources
// - Select bits reset to divide by 256
// - Run flag resets one; stabilisation wait
// - Run flag readable as counting status
// - Modulo at index 03H, low data byte
// - Count at 02H, held during read
// - Clear leaves prescaler running
`timescale 1ns/1ps
`include "ebmt_defines.vh"

module ebmt_top #(
   parameter AW = 8
) (
   input wire aclk,
   input wire aresetn,
   input wire [AW-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [AW-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire event_in,
   input wire service_ack,
   output wire service_req,
   output wire irq,
   output wire stab_done
);
   // Register byte addresses, one word apart
   localparam [AW-1:0] A_CTRL = `EBMT_IDX_CTRL * 8'd4;
   localparam [AW-1:0] A_STAT = `EBMT_IDX_STAT * 8'd4;
   localparam [AW-1:0] A_COUNT = `EBMT_IDX_COUNT * 8'd4;
   localparam [AW-1:0] A_MODULO = `EBMT_IDX_MODULO * 8'd4;
   localparam [AW-1:0] A_MASK = `EBMT_IDX_MASK * 8'd4;
   // Reset select code, split into its two flag bits
   localparam [1:0] RST_SEL = `EBMT_RST_SEL;

   reg [7:0] count_q;
   reg [7:0] count_d;
   reg [7:0] modulo_q;
   reg timer_run_flag_q;
   reg pulse_select_low_q;
   reg pulse_select_high_q;
   reg timer_irq_allow_q;
   reg gie_q;
   reg timer_request_flag_q;
   reg pend_q;
   reg pend_d;
   reg match_d;
   reg stat_q;
   reg mask_q;
   reg stab_q;
   reg [AW-1:0] awaddr_q;
   reg aw_got_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg w_got_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;
   wire pulse;
   wire do_wr;
   wire ar_hs;
   wire count_hold;
   wire clear_wr;
   wire ctrl_wr;
   wire stat_rd;
   wire inc;
   wire [7:0] ctrl_view;

   // Address decode shared by both paths
   function is_mapped;
      input [AW-1:0] a;
      begin
         is_mapped = (a == A_CTRL) || (a == A_STAT) || (a == A_COUNT) ||
                     (a == A_MODULO) || (a == A_MASK);
      end
   endfunction

   // Count pulse source
   ebmt_pulse_gen ebmt_pulse_gen_i (
      .aclk(aclk),
      .aresetn(aresetn),
      .sel({pulse_select_high_q, pulse_select_low_q}),
      .event_in(event_in),
      .pulse(pulse)
   );

   // Write channel: address and data taken in either order
   assign s_axi_awready = !aw_got_q && !bvalid_q;
   assign s_axi_wready = !w_got_q && !bvalid_q;
   assign do_wr = aw_got_q && w_got_q && !bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= {AW{1'b0}};
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `EBMT_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(awaddr_q) ? `EBMT_RESP_OKAY : `EBMT_RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Write effects; all fields sit in byte lane 0
   assign ctrl_wr = do_wr && wstrb_q[0] && (awaddr_q == A_CTRL);
   assign clear_wr = ctrl_wr && wdata_q[`EBMT_B_CLEAR];

   // Read channel: one outstanding read, data registered
   assign s_axi_arready = !rvalid_q;
   assign ar_hs = s_axi_arvalid && !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   // A count read freezes the counter in its address cycle
   assign count_hold = ar_hs && (s_axi_araddr == A_COUNT);
   assign stat_rd = ar_hs && (s_axi_araddr == A_STAT);

   // Control word as read back; the clear bit always reads zero
   assign ctrl_view = {1'b0, timer_request_flag_q, gie_q, timer_irq_allow_q,
                       pulse_select_high_q, pulse_select_low_q, 1'b0,
                       timer_run_flag_q};

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `EBMT_RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rresp_q <= is_mapped(s_axi_araddr) ? `EBMT_RESP_OKAY : `EBMT_RESP_SLVERR;
         case (s_axi_araddr)
            A_CTRL: rdata_q <= {24'h000000, ctrl_view};
            A_STAT: rdata_q <= {31'h00000000, stat_q};
            A_COUNT: rdata_q <= {24'h000000, count_q};
            A_MASK: rdata_q <= {31'h00000000, mask_q};
            default: rdata_q <= 32'h0000_0000; // Modulo reads zero
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Counting: a pulse during a count read is held and applied after
   assign inc = timer_run_flag_q && (pulse || pend_q) && !count_hold;

   always @* begin
      count_d = count_q;
      pend_d = pend_q;
      match_d = 1'b0;
      if (count_hold && pulse && timer_run_flag_q) begin
         pend_d = 1'b1;
      end else if (inc) begin
         pend_d = 1'b0;
      end
      if (clear_wr) begin
         count_d = 8'h00;
      end else if (inc) begin
         if (count_q == modulo_q) begin
            count_d = 8'h00;
            match_d = 1'b1;
         end else begin
            count_d = count_q + 8'h01;
         end
      end
   end

   // Count register and held pulse
   always @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= 8'h00;
         pend_q <= 1'b0;
      end else begin
         count_q <= count_d;
         pend_q <= pend_d;
      end
   end

   // Modulo is loaded only by a transfer; count writes are ignored
   always @(posedge aclk) begin
      if (!aresetn) begin
         modulo_q <= `EBMT_RST_MODULO;
      end else if (do_wr && wstrb_q[0] && awaddr_q == A_MODULO) begin
         modulo_q <= wdata_q[7:0];
      end
   end

   // Control flags
   always @(posedge aclk) begin
      if (!aresetn) begin
         timer_run_flag_q <= `EBMT_RST_RUN;
         pulse_select_low_q <= RST_SEL[0];
         pulse_select_high_q <= RST_SEL[1];
         timer_irq_allow_q <= 1'b0;
         gie_q <= 1'b0;
      end else if (ctrl_wr) begin
         timer_run_flag_q <= wdata_q[`EBMT_B_RUN];
         pulse_select_low_q <= wdata_q[`EBMT_B_SEL_LO];
         pulse_select_high_q <= wdata_q[`EBMT_B_SEL_HI];
         timer_irq_allow_q <= wdata_q[`EBMT_B_ALLOW];
         gie_q <= wdata_q[`EBMT_B_GIE];
      end
   end

   // Request flag: match sets, acceptance or software write one clears
   always @(posedge aclk) begin
      if (!aresetn) begin
         timer_request_flag_q <= 1'b0;
      end else if (match_d) begin
         timer_request_flag_q <= 1'b1;
      end else if ((service_ack && service_req) ||
                   (ctrl_wr && wdata_q[`EBMT_B_REQ])) begin
         timer_request_flag_q <= 1'b0;
      end
   end

   // Request reaches the core only when both enables are on
   assign service_req = timer_request_flag_q && gie_q && timer_irq_allow_q;

   // Sticky status cleared by read, set wins; mask gates the line
   always @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= 1'b0;
         mask_q <= 1'b0;
      end else begin
         if (match_d) begin
            stat_q <= 1'b1;
         end else if (stat_rd) begin
            stat_q <= 1'b0;
         end
         if (do_wr && wstrb_q[0] && awaddr_q == A_MASK) begin
            mask_q <= wdata_q[0];
         end
      end
   end

   // Level interrupt from unmasked sticky status
   assign irq = stat_q && mask_q;

   // First match after reset ends the stabilisation wait
   always @(posedge aclk) begin
      if (!aresetn) begin
         stab_q <= 1'b0;
      end else if (match_d) begin
         stab_q <= 1'b1;
      end
   end

   // Stabilisation wait over
   assign stab_done = stab_q;

endmodule

// [test/ebmt_sva.sv]
/*
 Checker for the modulo timer's bus handshakes, service request and
 stabilisation flag. Bound to ebmt_top; one clock, sync active-low reset.
*/
`timescale 1ns/1ps
module ebmt_sva #(parameter AW = 8) (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire service_ack,
   input wire service_req,
   input wire stab_done
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Both write halves taken at one edge
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   AST_BLAT: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   AST_RLAT: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read data late");
   AST_ARREADY: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("address taken while data pending");
   AST_WREADY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped");
   AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_RERR: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
      else $error("error read returned data");
   AST_SACK: assert property (service_req && service_ack |=> !service_req)
      else $error("request kept after acceptance");
   AST_STAB: assert property (stab_done |=> stab_done)
      else $error("stabilisation flag fell");
endmodule
bind ebmt_top ebmt_sva #(.AW(AW)) ebmt_sva_i (.*);

// [test/ebmt_top_tb.sv]
/*
 Self-checking bench for ebmt_top: register accesses over AXI4-Lite,
 event pin pulses and service handshake. Assumes a 10 MHz clock.
*/
`timescale 1ns/1ps
module ebmt_top_tb;
   logic aclk = 0, aresetn = 0, event_in = 0, service_ack = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire service_req, irq, stab_done;
   int error_cnt = 0, cmp_count = 0, cyc = 0, t0;
   ebmt_top ebmt_top_i (.*);
   // Clock and cycle count
   always #50 aclk = ~aclk;
   always @(posedge aclk) cyc <= cyc + 1;
   task final_report;
      $display("checks %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         error_cnt++;
      end
   endtask
   // Write with both halves offered together, each released at its own take edge
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ta, tw, ga, gw, b;
      ta = 0;
      tw = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(ta && tw)) begin
         @(negedge aclk);
         ga = s_axi_awvalid && s_axi_awready;
         gw = s_axi_wvalid && s_axi_wready;
         @(posedge aclk);
         if (ga) s_axi_awvalid <= 0;
         if (gw) s_axi_wvalid <= 0;
         ta = ta | ga;
         tw = tw | gw;
      end
      do begin
         @(negedge aclk);
         b = s_axi_bvalid;
         if (b) chk({30'h0, s_axi_bresp}, {30'h0, r});
         @(posedge aclk);
      end while (!b);
      s_axi_bready <= 0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      logic b;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(negedge aclk);
         b = s_axi_arready;
         @(posedge aclk);
      end while (!b);
      s_axi_arvalid <= 0;
      do begin
         @(negedge aclk);
         b = s_axi_rvalid;
         if (b) begin
            chk(s_axi_rdata, e);
            chk({30'h0, s_axi_rresp}, {30'h0, r});
         end
         @(posedge aclk);
      end while (!b);
      s_axi_rready <= 0;
   endtask
   // Wait for the interrupt line, note the cycle; running out is a mismatch
   task wait_irq(input int lim);
      int n;
      n = 0;
      do begin
         @(negedge aclk);
         n++;
      end while (irq !== 1'b1 && n < lim);
      if (irq !== 1'b1) begin
         $display("wrong value at %0t: no interrupt", $time);
         error_cnt++;
      end
      t0 = cyc;
   endtask
   task ev_pulse;
      @(posedge aclk) event_in <= 1;
      repeat (4) @(posedge aclk);
      event_in <= 0;
      repeat (4) @(posedge aclk);
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge aclk);
      $display("wrong value at %0t: watchdog expired", $time);
      error_cnt++;
      final_report;
   end
   initial begin
      int ta;
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      rd(8'h00, 32'h01, 2'h0);
      rd(8'h0c, 32'h0, 2'h0);
      rd(8'h08, 32'h0, 2'h0);
      rd(8'h14, 32'h0, 2'h2);
      wr(8'h14, 32'h1, 2'h2);
      wr(8'h08, 32'hff, 2'h0);
      rd(8'h08, 32'h0, 2'h0);
      // Modulo 3 on divide by 32 gives 128 cycles a period
      wr(8'h0c, 32'h03, 2'h0);
      wr(8'h10, 32'h01, 2'h0);
      wr(8'h00, 32'h07, 2'h0);
      wait_irq(400);
      chk(irq, 1);
      chk(stab_done, 1);
      wr(8'h00, 32'h35, 2'h0);
      @(negedge aclk) chk(service_req, 1);
      rd(8'h00, 32'h75, 2'h0);
      @(posedge aclk) service_ack <= 1;
      @(posedge aclk) service_ack <= 0;
      @(negedge aclk) chk(service_req, 0);
      rd(8'h04, 32'h1, 2'h0);
      rd(8'h04, 32'h0, 2'h0);
      @(negedge aclk) chk(irq, 0);
      wait_irq(400);
      ta = t0;
      rd(8'h04, 32'h1, 2'h0);
      wait_irq(400);
      chk(t0 - ta, 128);
      // Event pin counting, then stop with the run flag clear
      wr(8'h00, 32'h0f, 2'h0);
      @(negedge aclk) chk(service_req, 0);
      rd(8'h04, 32'h1, 2'h0);
      repeat (3) ev_pulse;
      rd(8'h08, 32'h3, 2'h0);
      wr(8'h00, 32'h0c, 2'h0);
      rd(8'h00, 32'h4c, 2'h0);
      ev_pulse;
      rd(8'h08, 32'h3, 2'h0);
      // Masked match keeps the line low until unmasked
      wr(8'h10, 32'h0, 2'h0);
      wr(8'h00, 32'h0d, 2'h0);
      ev_pulse;
      @(negedge aclk) chk(irq, 0);
      rd(8'h08, 32'h0, 2'h0);
      wr(8'h10, 32'h1, 2'h0);
      @(negedge aclk) chk(irq, 1);
      // Modulo 1 gives two pulses a period on the slow and middle taps
      rd(8'h04, 32'h1, 2'h0);
      wr(8'h0c, 32'h01, 2'h0);
      wr(8'h00, 32'h09, 2'h0);
      wait_irq(5000);
      rd(8'h04, 32'h1, 2'h0);
      ta = t0;
      wait_irq(5000);
      chk(t0 - ta, 4096);
      rd(8'h04, 32'h1, 2'h0);
      wr(8'h00, 32'h01, 2'h0);
      wait_irq(5000);
      rd(8'h04, 32'h1, 2'h0);
      ta = t0;
      wait_irq(5000);
      chk(t0 - ta, 512);
      // Clear at count 1 mid-interval; prescaler phase is kept
      rd(8'h04, 32'h1, 2'h0);
      ta = t0;
      repeat (300) @(posedge aclk);
      wr(8'h00, 32'h03, 2'h0);
      wait_irq(5000);
      chk(t0 - ta, 768);
      final_report;
   end
endmodule
